// ==== rtl/pbad_consts.svh ====
// Constants for the peripheral block access decoder.
`ifndef PBAD_CONSTS_SVH
`define PBAD_CONSTS_SVH

// Relocation register: offset in block, reset value, writable bits.
`define PBAD_RELOC_OFS 8'ha8
`define PBAD_RELOC_RESET 16'h00ff
`define PBAD_RELOC_WMASK 16'h9fff
`define PBAD_ET_BIT 15
`define PBAD_MEM_BIT 12
`define PBAD_BASE_MSB 11
`define PBAD_IO_BASE_MSB 7
`define PBAD_IO_BASE_ZERO 8'h00

// Word maps of the block, bit n standing for the word at offset 2n.
`define PBAD_RESERVED_MAP 128'hc0c0_c000_20e0_0000_c0c0_0004_00c0_ff10
`define PBAD_TIMER_MAP 128'h0000_0000_0000_0000_0000_000b_ff00_0000

// Coprocessor interface I/O window, address bits 15 to 3.
`define PBAD_COPROC_PAGE 13'h001f
`define PBAD_IO_HIGH_ZERO 4'h0

`endif

// ==== rtl/pbad_pkg.sv ====
// Types and the shared function of the peripheral block access decoder.
package pbad_pkg;

  typedef enum logic [2:0] {PH_IDLE, PH_ACCESS, PH_WAIT, PH_SECOND, PH_EXT, PH_DONE} pbad_phase_t;

  typedef struct packed {
    pbad_phase_t phase;
    logic ext_sync1;
    logic ext_sync2;
    logic [15:0] reloc;
    logic [19:0] addr;
    logic write;
    logic byte_op;
    logic inta;
    logic [15:0] wdata;
    logic timer;
    logic hit;
    logic fbus_sel;
    logic fbus_write;
    logic [6:0] fbus_addr;
    logic [15:0] fbus_wdata;
    logic [15:0] rdata;
    logic ext_cycle;
    logic esc_trap;
  } pbad_state_t;

  function automatic logic [15:0] pbad_swap(input logic [15:0] w);
    pbad_swap = {w[7:0], w[15:8]};
  endfunction

endpackage

// ==== rtl/pbad_int_if.sv ====
// Internal carrier between the access decoder top and its decode and lane helpers.
`timescale 1ns/100ps
interface pbad_int_if;
  // Address decode group.
  logic [19:0] addr;
  logic is_mem;
  logic [15:0] reloc;
  logic hit;
  logic [7:0] offset;
  logic assigned;
  logic timer;
  logic reloc_sel;
  logic coproc;
  // Byte lane group.
  logic odd;
  logic byte_op;
  logic [15:0] cpu_wdata;
  logic [15:0] word_in;
  logic [15:0] lane_wdata;
  logic [15:0] lane_rdata;

  modport top (output addr, is_mem, reloc, odd, byte_op, cpu_wdata, word_in,
               input hit, offset, assigned, timer, reloc_sel, coproc, lane_wdata, lane_rdata);
  modport dec (input addr, is_mem, reloc,
               output hit, offset, assigned, timer, reloc_sel, coproc);
  modport lane (input odd, byte_op, cpu_wdata, word_in, output lane_wdata, lane_rdata);
endinterface

// ==== rtl/pbad_decode.sv ====
// Block hit and offset classification against the relocation register.
`timescale 1ns/100ps
`include "pbad_consts.svh"
module pbad_decode
  import pbad_pkg::*;
(
  // Decode group.
  pbad_int_if.dec d
);

  logic [127:0] reserved_map;
  logic [127:0] timer_map;
  logic space_ok;
  logic base_ok;

  assign reserved_map = `PBAD_RESERVED_MAP;
  assign timer_map = `PBAD_TIMER_MAP;

  // In I/O space only the low byte of the base and 16 address bits matter.
  always_comb
  begin
    space_ok = (d.is_mem == d.reloc[`PBAD_MEM_BIT]);
    if (d.reloc[`PBAD_MEM_BIT])
      base_ok = (d.addr[19:8] == d.reloc[`PBAD_BASE_MSB:0]);
    else
      base_ok = (d.addr[15:8] == d.reloc[`PBAD_IO_BASE_MSB:0]);
  end

  assign d.hit = space_ok && base_ok;
  assign d.offset = d.addr[7:0];
  assign d.assigned = !reserved_map[d.addr[7:1]];
  assign d.timer = timer_map[d.addr[7:1]];
  assign d.reloc_sel = (d.addr[7:1] == `PBAD_RELOC_OFS >> 1);
  // The block wins over the coprocessor window when they overlap.
  assign d.coproc = !d.is_mem && !d.hit && (d.addr[19:16] == `PBAD_IO_HIGH_ZERO)
                    && (d.addr[15:3] == `PBAD_COPROC_PAGE);

endmodule

// ==== rtl/pbad_lane.sv ====
// Byte lane steering between the CPU data path and the 16-bit peripheral bus.
`timescale 1ns/100ps
module pbad_lane
  import pbad_pkg::*;
(
  // Lane group.
  pbad_int_if.lane l
);

  // Writes are always whole words; an odd offset puts the low byte at the odd half.
  assign l.lane_wdata = l.odd ? pbad_swap(l.cpu_wdata) : l.cpu_wdata;

  // Odd word reads swap halves; byte reads return only the addressed byte.
  always_comb
  begin
    if (l.byte_op)
      l.lane_rdata = {8'h00, l.odd ? l.word_in[15:8] : l.word_in[7:0]};
    else if (l.odd)
      l.lane_rdata = pbad_swap(l.word_in);
    else
      l.lane_rdata = l.word_in;
  end

endmodule

// ==== rtl/pbad_top.sv ====
// Access decoder for the relocatable 256-byte peripheral register block.
`timescale 1ns/100ps
`include "pbad_consts.svh"
module pbad_top
  import pbad_pkg::*;
#(
  parameter bit BUS8 = 1'b0
)
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // CPU bus cycle request.
  input wire logic cyc_req,
  input wire logic [19:0] cyc_addr,
  input wire logic cyc_is_mem,
  input wire logic cyc_write,
  input wire logic cyc_byte,
  input wire logic cyc_inta,
  input wire logic [15:0] cyc_wdata,
  output logic cyc_ready,
  output logic [15:0] cyc_rdata,
  // External bus mirror.
  input wire logic ext_ready_pin,
  output logic ext_cycle,
  output logic ext_data_discard,
  // Interrupt controller mode.
  input wire logic cascade_mode,
  // Internal peripheral bus.
  output logic fbus_sel,
  output logic fbus_write,
  output logic [6:0] fbus_addr,
  output logic [15:0] fbus_wdata,
  output logic fbus_timer,
  input wire logic [15:0] fbus_rdata,
  // Coprocessor interface.
  input wire logic esc_opcode,
  output logic esc_trap,
  output logic coproc_sel,
  // Relocation value.
  output logic [15:0] reloc_value
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  pbad_int_if bus ();
  pbad_state_t q;
  pbad_state_t next_q;
  logic io_at_zero;
  logic ext_ok;
  logic two_cycles;
  logic [15:0] read_word;

  pbad_decode u_decode
  (
    .d(bus.dec)
  );

  pbad_lane u_lane
  (
    .l(bus.lane)
  );

  // The second byte cycle is decoded with the relocation value already updated.
  always_comb
  begin
    bus.reloc = q.reloc;
    if (q.phase == PH_IDLE)
    begin
      bus.addr = cyc_addr;
      bus.is_mem = cyc_is_mem;
    end
    else if (q.phase == PH_SECOND)
    begin
      bus.addr = q.addr + 20'h00001;
      bus.is_mem = q.reloc[`PBAD_MEM_BIT];
    end
    else
    begin
      bus.addr = q.addr;
      bus.is_mem = q.reloc[`PBAD_MEM_BIT];
    end
  end

  always_comb
  begin
    if (q.phase == PH_IDLE)
    begin
      bus.odd = cyc_addr[0];
      bus.byte_op = cyc_byte;
      bus.cpu_wdata = cyc_wdata;
    end
    else
    begin
      bus.odd = q.addr[0];
      bus.byte_op = q.byte_op;
      bus.cpu_wdata = q.wdata;
    end
  end

  // Reserved offsets read as zero, which is one legal undefined value.
  always_comb
  begin
    if (bus.reloc_sel)
      read_word = q.reloc;
    else if (bus.assigned)
      read_word = fbus_rdata;
    else
      read_word = 16'h0000;
  end
  assign bus.word_in = read_word;

  assign io_at_zero = !q.reloc[`PBAD_MEM_BIT]
                      && (q.reloc[`PBAD_IO_BASE_MSB:0] == `PBAD_IO_BASE_ZERO);
  // External ready is taken through the two-stage synchroniser, except for cascade acknowledges with the block at I/O zero.
  assign ext_ok = q.ext_sync2 || (q.inta && cascade_mode && io_at_zero);
  assign two_cycles = BUS8 && !q.byte_op;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    next_q = q;
    next_q.ext_sync1 = ext_ready_pin;
    next_q.ext_sync2 = q.ext_sync1;
    next_q.ext_cycle = 1'b0;
    next_q.fbus_sel = 1'b0;
    next_q.fbus_write = 1'b0;
    next_q.esc_trap = esc_opcode && (q.reloc[`PBAD_ET_BIT] || BUS8);
    case (q.phase)
      PH_IDLE:
      begin
        if (cyc_req)
        begin
          next_q.addr = cyc_addr;
          next_q.write = cyc_write;
          next_q.byte_op = cyc_byte;
          next_q.inta = cyc_inta;
          next_q.wdata = cyc_wdata;
          next_q.rdata = 16'h0000;
          next_q.ext_cycle = 1'b1;
          next_q.hit = bus.hit;
          next_q.timer = bus.timer;
          if (bus.hit)
          begin
            // Whole-word transfer on the internal bus, stores only to assigned words.
            next_q.fbus_sel = 1'b1;
            next_q.fbus_write = cyc_write && bus.assigned && !bus.reloc_sel;
            next_q.fbus_addr = cyc_addr[7:1];
            next_q.fbus_wdata = bus.lane_wdata;
            next_q.phase = PH_ACCESS;
          end
          else
            next_q.phase = PH_EXT;
        end
      end
      PH_ACCESS:
      begin
        next_q.rdata = bus.lane_rdata;
        if (q.write && bus.reloc_sel)
          next_q.reloc = bus.lane_wdata & `PBAD_RELOC_WMASK;
        if (q.timer)
          next_q.phase = PH_WAIT;
        else if (two_cycles)
          next_q.phase = PH_SECOND;
        else
          next_q.phase = PH_DONE;
      end
      PH_WAIT:
      begin
        if (two_cycles)
          next_q.phase = PH_SECOND;
        else
          next_q.phase = PH_DONE;
      end
      PH_SECOND:
      begin
        // A block moved by the first byte leaves the second cycle outside it.
        next_q.ext_cycle = 1'b1;
        next_q.hit = bus.hit;
        if (bus.hit)
          next_q.phase = PH_DONE;
        else
          next_q.phase = PH_EXT;
      end
      PH_EXT:
      begin
        if (ext_ok)
          next_q.phase = PH_IDLE;
      end
      PH_DONE:
      begin
        next_q.phase = PH_IDLE;
      end
      default:
      begin
        next_q.phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      q <= '0;
      q.phase <= PH_IDLE;
      q.reloc <= `PBAD_RELOC_RESET;
    end
    else
      q <= next_q;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Inside the block ready is internal only; outside it comes from the pin, or at once for cascade acknowledges with the block at I/O zero.
  assign cyc_ready = (q.phase == PH_DONE) || ((q.phase == PH_EXT) && ext_ok);
  assign cyc_rdata = q.rdata;
  assign ext_cycle = q.ext_cycle;
  assign ext_data_discard = q.hit && (q.phase != PH_IDLE) && (q.phase != PH_EXT);
  assign fbus_sel = q.fbus_sel;
  assign fbus_write = q.fbus_write;
  assign fbus_addr = q.fbus_addr;
  assign fbus_wdata = q.fbus_wdata;
  assign fbus_timer = q.timer;
  assign esc_trap = q.esc_trap;
  assign coproc_sel = (q.phase == PH_IDLE) && cyc_req && bus.coproc;
  assign reloc_value = q.reloc;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  a_reloc_write_src: assert property (!$stable(q.reloc) |->
    $past(q.phase == PH_ACCESS && q.write && bus.reloc_sel))
    else $error("relocation changed without a write to its offset");

  a_reloc_full_load: assert property ((q.phase == PH_ACCESS && q.write && bus.reloc_sel) |=>
    q.reloc == ($past(bus.lane_wdata) & `PBAD_RELOC_WMASK))
    else $error("relocation did not load the whole word");

  a_reserved_nowrite: assert property (fbus_write |->
    $past(q.phase == PH_IDLE && bus.assigned && !bus.reloc_sel))
    else $error("store to a reserved offset");

  a_zero_wait: assert property ((q.phase == PH_ACCESS && !q.timer && !two_cycles) |=>
    cyc_ready)
    else $error("untimed block access did not end at once");

  a_timer_wait: assert property ((q.phase == PH_ACCESS && q.timer && !two_cycles) |=>
    !cyc_ready ##1 cyc_ready)
    else $error("timer access wait state wrong");

  a_internal_ready: assert property ((q.phase == PH_IDLE && cyc_req && bus.hit && !BUS8) |=>
    ##[1:2] cyc_ready)
    else $error("block access missed internal ready");

  a_ext_mirror: assert property ((q.phase == PH_IDLE && cyc_req) |=> ext_cycle)
    else $error("no external cycle mirrored");

  a_two_cycles: assert property ((q.phase == PH_IDLE && cyc_req && bus.hit && BUS8
    && !cyc_byte && !bus.timer) |=> ext_cycle ##1 !ext_cycle ##1 ext_cycle)
    else $error("8-bit word access did not run two cycles");

  a_write_lanes: assert property (fbus_write |->
    fbus_wdata == (q.addr[0] ? pbad_swap(q.wdata) : q.wdata))
    else $error("write byte lanes wrong");

  a_esc_trap: assert property ((esc_opcode && (q.reloc[`PBAD_ET_BIT] || BUS8)) |=>
    esc_trap)
    else $error("escape opcode not trapped");

  a_cascade_ready: assert property ((q.phase == PH_EXT && q.inta && cascade_mode
    && io_at_zero) |-> cyc_ready)
    else $error("acknowledge waited with block at I/O zero");

  a_hit_space: assert property ((q.phase == PH_IDLE && bus.hit) |->
    cyc_is_mem == q.reloc[`PBAD_MEM_BIT])
    else $error("hit in the wrong address space");

  a_coproc_yield: assert property (coproc_sel |-> !bus.hit)
    else $error("coprocessor selected inside the block");

  c_timer_access: cover property (q.phase == PH_WAIT ##1 cyc_ready);
  c_reloc_write: cover property (q.phase == PH_ACCESS && q.write && bus.reloc_sel);
  c_moved_second: cover property (q.phase == PH_SECOND && !bus.hit);
  c_odd_read: cover property (q.phase == PH_ACCESS && !q.write && q.addr[0]);

endmodule

// ==== bench/pbad_periph_model.sv ====
// Peripheral register and external ready model for the access decoder bench.
`timescale 1ns/100ps
module pbad_periph_model
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Request watch.
  input wire logic cyc_req,
  // Internal peripheral bus.
  input wire logic fbus_sel,
  input wire logic fbus_write,
  input wire logic [6:0] fbus_addr,
  input wire logic [15:0] fbus_wdata,
  output logic [15:0] fbus_rdata,
  // External ready.
  output logic ext_ready_pin
);
  logic [15:0] regs [0:127];
  int req_cycles;

  // ==========================================================
  // Register storage, whole words only.
  always @(posedge sys_clk)
  begin
    if (fbus_sel && fbus_write)
    begin
      regs[fbus_addr] <= fbus_wdata;
    end
  end

  assign fbus_rdata = regs[fbus_addr];

  // ==========================================================
  // External logic answers any cycle after a few cycles of request.
  // Ready falls with the request, so no stale level crosses the synchroniser into the next cycle.
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      req_cycles <= 0;
    end
    else
    begin
      req_cycles <= cyc_req ? req_cycles + 1 : 0;
    end
  end

  // A late ready keeps block timing apart from the external path.
  assign ext_ready_pin = cyc_req && (req_cycles >= 3);
endmodule

// ==== bench/peripheral_block_access_decoder_tb_top.sv ====
// Self-checking bench for the peripheral block access decoder.
`timescale 1ns/100ps
module peripheral_block_access_decoder_tb_top;
  import pbad_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cyc_req = 1'b0;
  logic [19:0] cyc_addr = 20'h00000;
  logic cyc_is_mem = 1'b0;
  logic cyc_write = 1'b0;
  logic cyc_byte = 1'b0;
  logic [15:0] cyc_wdata = 16'h0000;
  logic esc_opcode = 1'b0;
  logic cyc_inta = 1'b0;
  logic cascade_mode = 1'b0;
  logic ext_ready_pin, cyc_ready, ext_cycle, fbus_sel, fbus_write, esc_trap, coproc_sel;
  logic discard, fbus_timer, b8_ext, b8_trap;
  logic [15:0] b8_rdata;
  logic [15:0] cyc_rdata, fbus_wdata, fbus_rdata, reloc_value, q, d, r;
  logic [6:0] fbus_addr;
  int err_count = 0;
  int check_count = 0;
  int ext_cnt = 0;
  int cop_cnt = 0;
  int ext8_cnt = 0;
  int dis_cnt = 0;
  int tmr_cnt = 0;
  int lat, e0, e8, i;

  pbad_top u_pbad_top (.sys_clk(sys_clk), .reset(reset), .cyc_req(cyc_req),
    .cyc_addr(cyc_addr), .cyc_is_mem(cyc_is_mem), .cyc_write(cyc_write),
    .cyc_byte(cyc_byte), .cyc_inta(cyc_inta), .cyc_wdata(cyc_wdata), .cyc_ready(cyc_ready),
    .cyc_rdata(cyc_rdata), .ext_ready_pin(ext_ready_pin), .ext_cycle(ext_cycle),
    .ext_data_discard(discard), .cascade_mode(cascade_mode), .fbus_sel(fbus_sel),
    .fbus_write(fbus_write), .fbus_addr(fbus_addr), .fbus_wdata(fbus_wdata),
    .fbus_timer(fbus_timer), .fbus_rdata(fbus_rdata), .esc_opcode(esc_opcode),
    .esc_trap(esc_trap), .coproc_sel(coproc_sel), .reloc_value(reloc_value));

  // The 8-bit variant follows the same stimulus; its block cycles end before the next request.
  pbad_top #(.BUS8(1'b1)) u_pbad_top_bus8 (.sys_clk(sys_clk), .reset(reset),
    .cyc_req(cyc_req), .cyc_addr(cyc_addr), .cyc_is_mem(cyc_is_mem),
    .cyc_write(cyc_write), .cyc_byte(cyc_byte), .cyc_inta(cyc_inta),
    .cyc_wdata(cyc_wdata), .cyc_ready(), .cyc_rdata(b8_rdata),
    .ext_ready_pin(ext_ready_pin), .ext_cycle(b8_ext), .ext_data_discard(),
    .cascade_mode(cascade_mode), .fbus_sel(), .fbus_write(), .fbus_addr(),
    .fbus_wdata(), .fbus_timer(), .fbus_rdata(fbus_rdata), .esc_opcode(esc_opcode),
    .esc_trap(b8_trap), .coproc_sel(), .reloc_value());

  pbad_periph_model u_pbad_periph_model (.sys_clk(sys_clk), .reset(reset),
    .cyc_req(cyc_req), .fbus_sel(fbus_sel), .fbus_write(fbus_write),
    .fbus_addr(fbus_addr), .fbus_wdata(fbus_wdata), .fbus_rdata(fbus_rdata),
    .ext_ready_pin(ext_ready_pin));

  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    if (ext_cycle === 1'b1) ext_cnt <= ext_cnt + 1;
    if (coproc_sel === 1'b1) cop_cnt <= cop_cnt + 1;
    if (b8_ext === 1'b1) ext8_cnt <= ext8_cnt + 1;
    if (ext_cycle === 1'b1 && discard === 1'b1) dis_cnt <= dis_cnt + 1;
    if (fbus_sel === 1'b1 && fbus_timer === 1'b1) tmr_cnt <= tmr_cnt + 1;
  end

  // ==========================================================
  // Checking and closing.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // ==========================================================
  // One CPU cycle; lat counts falling edges from request to ready.
  task automatic acc(input logic [19:0] a, input logic m, input logic w, input logic b,
                     input logic [15:0] wd, output logic [15:0] rd, output int n);
    @(posedge sys_clk);
    cyc_req <= 1'b1;
    cyc_addr <= a;
    cyc_is_mem <= m;
    cyc_write <= w;
    cyc_byte <= b;
    cyc_wdata <= wd;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
      if (n > 60)
      begin
        err_count++;
        tally_and_finish();
      end
    end
    while (cyc_ready !== 1'b1);
    rd = cyc_rdata;
    @(posedge sys_clk);
    cyc_req <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk("reset relocation", 16'h00ff, reloc_value);
    e0 = ext_cnt;
    e8 = ext8_cnt;
    acc(20'h0ff00, 1'b0, 1'b1, 1'b0, 16'h5a3c, q, lat);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("block ext cycles", 16'h0001, 16'(ext_cnt - e0));
    chk("data discard", 16'h0001, 16'(dis_cnt));
    chk("8-bit word ext cycles", 16'h0002, 16'(ext8_cnt - e8));
    acc(20'h0ff00, 1'b0, 1'b0, 1'b0, 16'h0000, q, lat);
    chk("word read", 16'h5a3c, q);
    chk("8-bit word read", 16'h5a3c, b8_rdata);
    chk("zero wait latency", 16'h0003, 16'(lat));
    chk("ext ready ignored", 16'h0003, 16'(lat));
    acc(20'h0ff30, 1'b0, 1'b0, 1'b0, 16'h0000, q, lat);
    chk("timer latency", 16'h0004, 16'(lat));
    chk("timer flag", 16'h0001, 16'(tmr_cnt));
    acc(20'hfff02, 1'b0, 1'b1, 1'b1, 16'habcd, q, lat);
    acc(20'hfff02, 1'b0, 1'b0, 1'b0, 16'h0000, q, lat);
    chk("even byte write", 16'habcd, q);
    chk("io upper ignored", 16'h0003, 16'(lat));
    acc(20'h0ff05, 1'b0, 1'b1, 1'b0, 16'h1234, q, lat);
    acc(20'h0ff04, 1'b0, 1'b0, 1'b0, 16'h0000, q, lat);
    chk("odd write lanes", 16'h3412, q);
    acc(20'h0ff05, 1'b0, 1'b0, 1'b0, 16'h0000, q, lat);
    chk("odd word read", 16'h1234, q);
    acc(20'h0ff05, 1'b0, 1'b0, 1'b1, 16'h0000, q, lat);
    chk("odd byte read", 16'h0034, q);
    acc(20'h0ff04, 1'b0, 1'b0, 1'b1, 16'h0000, q, lat);
    chk("even byte read", 16'h0012, q);
    acc(20'h0ff08, 1'b0, 1'b1, 1'b0, 16'h0000, q, lat);
    acc(20'h0ff08, 1'b0, 1'b0, 1'b0, 16'h0000, q, lat);
    chk("reserved read", 16'h0000, q);
    chk("reserved latency", 16'h0003, 16'(lat));
    // Random words over assigned plain offsets.
    r = 16'h004c;
    for (i = 0; i < 8; i++)
    begin
      r = lfsr(r);
      d = r;
      acc({12'h0ff, 4'h0, r[2:1], 2'b10}, 1'b0, 1'b1, 1'b0, d, q, lat);
      acc({12'h0ff, 4'h0, r[2:1], 2'b10}, 1'b0, 1'b0, 1'b0, 16'h0000, q, lat);
      chk("random word", d, q);
    end
    // No trap in the 16-bit variant while the escape trap bit is clear.
    @(posedge sys_clk);
    esc_opcode <= 1'b1;
    @(posedge sys_clk);
    esc_opcode <= 1'b0;
    @(negedge sys_clk);
    chk("trap clear", 16'h0000, {15'h0, esc_trap});
    chk("8-bit trap", 16'h0001, {15'h0, b8_trap});
    // Move the block to memory with a byte write.
    acc(20'h0ffa8, 1'b0, 1'b1, 1'b1, 16'h1100, q, lat);
    chk("relocation value", 16'h1100, reloc_value);
    acc(20'h10000, 1'b1, 1'b0, 1'b0, 16'h0000, q, lat);
    chk("memory block hit", 16'h0003, 16'(lat));
    e0 = dis_cnt;
    acc(20'h0ff00, 1'b0, 1'b0, 1'b0, 16'h0000, q, lat);
    chk("old base missed", 16'h0001, {15'h0, lat > 3});
    chk("miss keeps data", 16'h0000, 16'(dis_cnt - e0));
    acc(20'h000f8, 1'b0, 1'b0, 1'b0, 16'h0000, q, lat);
    chk("coprocessor select", 16'h0001, {15'h0, cop_cnt > 0});
    // Back to I/O through the moved register, with masked bits set.
    acc(20'h100a8, 1'b1, 1'b1, 1'b1, 16'he0ff, q, lat);
    chk("relocation moved", 16'h80ff, reloc_value);
    acc(20'h0ffa8, 1'b0, 1'b0, 1'b0, 16'h0000, q, lat);
    chk("relocation read", 16'h80ff, q);
    @(posedge sys_clk);
    esc_opcode <= 1'b1;
    @(posedge sys_clk);
    esc_opcode <= 1'b0;
    @(negedge sys_clk);
    chk("trap set", 16'h0001, {15'h0, esc_trap});
    // Block at I/O zero in cascade mode: acknowledges outside it get no wait states.
    acc(20'h0ffa8, 1'b0, 1'b1, 1'b1, 16'h0000, q, lat);
    chk("relocation to zero", 16'h0000, reloc_value);
    cascade_mode <= 1'b1;
    cyc_inta <= 1'b1;
    acc(20'h00100, 1'b0, 1'b0, 1'b0, 16'h0000, q, lat);
    chk("cascade acknowledge", 16'h0002, 16'(lat));
    tally_and_finish();
  end
endmodule
